// file: verilog/mter_top.sv
// message transfer request checking and error code reporting
//
// Function
// - A transfer request on a station not in master role is refused with BC06.
// - A transfer request whose send size lies outside the allowed range gets BC07.
// - A link error on the target station aborts its transfer with BC50.
// - A link parameter change during a transfer ends it with BC50.
// - Each handshake step is timed against the monitoring time word; expiry gives BC52 or BC53.
// - The link stop request bit during a transfer times it out with BC52 or BC53.
// - Abnormal data end a transfer with BC50, BC51, BC54, BC55 or BC58 by stage.
// - A transfer or peripheral access to a station already pending is refused with BC57.
// - An abnormal response from the target station gives BC5B.
// - A fifth concurrent transfer is refused with BC60; four may run at once.
`timescale 1ns/1ns
module mter_top #(
    parameter int TICK_CYCLES = mter_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire logic req_periph_i,
    input wire logic [mter_pkg::STN_W-1:0] req_stn_i,
    input wire logic [mter_pkg::SIZE_W-1:0] req_size_i,
    input wire logic master_role_i,
    input wire logic [mter_pkg::MON_W-1:0] monitoring_time_word_i,
    input wire logic link_stop_request_bit_i,
    input wire logic param_chg_i,
    input wire logic link_err_i,
    input wire logic [mter_pkg::STN_W-1:0] link_err_stn_i,
    input wire mter_pkg::mter_rx_e rx_kind_i,
    input wire logic [mter_pkg::STN_W-1:0] rx_stn_i,
    output logic done_o,
    output logic [mter_pkg::STN_W-1:0] done_stn_o,
    output logic [mter_pkg::CODE_W-1:0] err_code_o,
    output logic periph_grant_o,
    output logic [mter_pkg::CNT_W-1:0] busy_cnt_o
);
    import mter_pkg::*;

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // monitoring time base
    // ------------------------------------------------------------------
    logic [15:0] div_reg, div_next;
    logic tick_reg, tick_next;

    always_comb begin
        tick_next = (div_reg == TICK_LAST);
        div_next = tick_next ? '0 : div_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ------------------------------------------------------------------
    // transfer slots
    // ------------------------------------------------------------------
    mter_slot_if sif[MAX_XFER]();
    logic [MAX_XFER-1:0] sl_active, sl_fin, start_vec, ack_vec;
    logic [STN_W-1:0] sl_stn [MAX_XFER];
    logic [CODE_W-1:0] sl_code [MAX_XFER];

    for (genvar g = 0; g < MAX_XFER; g++) begin : g_slot
        assign sl_active[g] = sif[g].active;
        assign sl_fin[g] = sif[g].fin;
        assign sl_stn[g] = sif[g].stn;
        assign sl_code[g] = sif[g].code;
        assign sif[g].start = start_vec[g];
        assign sif[g].start_stn = req_stn_i;
        assign sif[g].ack = ack_vec[g];
        mter_slot u_slot (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .bus(sif[g]),
            .tick_i(tick_reg),
            .mon_time_i(monitoring_time_word_i),
            .link_stop_i(link_stop_request_bit_i),
            .param_chg_i(param_chg_i),
            .link_err_i(link_err_i),
            .link_err_stn_i(link_err_stn_i),
            .rx_kind_i(rx_kind_i),
            .rx_stn_i(rx_stn_i)
        );
    end

    // ------------------------------------------------------------------
    // request checks and report selection
    // ------------------------------------------------------------------
    logic pend_hit, any_free, size_bad, rej;
    logic [CODE_W-1:0] rej_code;
    logic [CNT_W-1:0] cnt;
    logic done_next, grant_next;
    logic [STN_W-1:0] dstn_next;
    logic [CODE_W-1:0] code_next;
    logic [CNT_W-1:0] busy_next;
    logic done_reg, grant_reg;
    logic [STN_W-1:0] dstn_reg;
    logic [CODE_W-1:0] code_reg;
    logic [CNT_W-1:0] busy_reg;

    always_comb begin
        pend_hit = 1'b0;
        any_free = 1'b0;
        cnt = '0;
        start_vec = '0;
        ack_vec = '0;
        for (int i = 0; i < MAX_XFER; i++) begin
            if (sl_active[i] && sl_stn[i] == req_stn_i)
                pend_hit = 1'b1;
            if (sl_active[i] || sl_fin[i])
                cnt = cnt + 3'h1;
            else
                any_free = 1'b1;
        end
        size_bad = (req_size_i < SIZE_MIN) || (req_size_i > SIZE_MAX);
        rej = req_valid_i;
        if (!master_role_i)
            rej_code = CODE_NOT_MASTER;
        else if (!req_periph_i && size_bad)
            rej_code = CODE_SIZE;
        else if (pend_hit)
            rej_code = CODE_OVERLAP;
        else if (!req_periph_i && !any_free)
            rej_code = CODE_TOO_MANY;
        else begin
            rej_code = CODE_OK;
            rej = 1'b0;
        end
        grant_next = req_valid_i && req_periph_i && !rej;
        if (req_valid_i && !req_periph_i && !rej) begin
            for (int i = MAX_XFER - 1; i >= 0; i--) begin
                if (!sl_active[i] && !sl_fin[i])
                    start_vec = 4'h1 << i;
            end
        end
        done_next = 1'b0;
        dstn_next = dstn_reg;
        code_next = code_reg;
        if (rej) begin
            done_next = 1'b1;
            dstn_next = req_stn_i;
            code_next = rej_code;
        end else begin
            for (int i = MAX_XFER - 1; i >= 0; i--) begin
                if (sl_fin[i]) begin
                    ack_vec = 4'h1 << i;
                    done_next = 1'b1;
                    dstn_next = sl_stn[i];
                    code_next = sl_code[i];
                end
            end
        end
        busy_next = cnt;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_reg <= 1'b0;
            grant_reg <= 1'b0;
            dstn_reg <= '0;
            code_reg <= CODE_OK;
            busy_reg <= '0;
        end else begin
            done_reg <= done_next;
            grant_reg <= grant_next;
            dstn_reg <= dstn_next;
            code_reg <= code_next;
            busy_reg <= busy_next;
        end
    end

    assign done_o = done_reg;
    assign periph_grant_o = grant_reg;
    assign done_stn_o = dstn_reg;
    assign err_code_o = code_reg;
    assign busy_cnt_o = busy_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_not_master_refuse: assert property (
        req_valid_i && !master_role_i |=> done_o && err_code_o == CODE_NOT_MASTER)
        else $error("non-master request not refused with BC06");
    chk_size_range: assert property (
        req_valid_i && master_role_i && !req_periph_i && size_bad
        |=> done_o && err_code_o == CODE_SIZE)
        else $error("bad send size not reported as BC07");
    chk_overlap_refuse: assert property (
        req_valid_i && master_role_i && (req_periph_i || !size_bad) && pend_hit
        |=> done_o && err_code_o == CODE_OVERLAP && !periph_grant_o)
        else $error("overlapping request not refused with BC57");
    chk_too_many: assert property (
        req_valid_i && master_role_i && !req_periph_i && !size_bad &&
        !pend_hit && cnt == CNT_W'(MAX_XFER)
        |=> done_o && err_code_o == CODE_TOO_MANY)
        else $error("fifth transfer not refused with BC60");
    chk_code_hold: assert property (
        !done_next |=> $stable(err_code_o) && !done_o)
        else $error("error code changed without a completion");
endmodule

// file: pkg/mter_pkg.sv
// constants, types and helpers of the message transfer error reporter
package mter_pkg;
    localparam int STN_W = 7;
    localparam int SIZE_W = 11;
    localparam int CODE_W = 16;
    localparam int MON_W = 16;
    localparam int MAX_XFER = 4;
    localparam int CNT_W = 3;
    localparam logic [SIZE_W-1:0] SIZE_MIN = 11'h001;
    localparam logic [SIZE_W-1:0] SIZE_MAX = 11'h3C0;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    // ------------------------------------------------------------------
    // error codes
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_OK = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_NOT_MASTER = 16'hBC06;
    localparam logic [CODE_W-1:0] CODE_SIZE = 16'hBC07;
    localparam logic [CODE_W-1:0] CODE_HS_50 = 16'hBC50;
    localparam logic [CODE_W-1:0] CODE_HS_51 = 16'hBC51;
    localparam logic [CODE_W-1:0] CODE_TOUT_REQ = 16'hBC52;
    localparam logic [CODE_W-1:0] CODE_TOUT_RSP = 16'hBC53;
    localparam logic [CODE_W-1:0] CODE_HS_54 = 16'hBC54;
    localparam logic [CODE_W-1:0] CODE_HS_55 = 16'hBC55;
    localparam logic [CODE_W-1:0] CODE_OVERLAP = 16'hBC57;
    localparam logic [CODE_W-1:0] CODE_HS_58 = 16'hBC58;
    localparam logic [CODE_W-1:0] CODE_BAD_RSP = 16'hBC5B;
    localparam logic [CODE_W-1:0] CODE_TOO_MANY = 16'hBC60;

    typedef enum logic [1:0] {
        RX_NONE, RX_STEP, RX_BAD_DATA, RX_BAD_RSP
    } mter_rx_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ_SEND, ST_REQ_ACK, ST_RSP_WAIT, ST_RSP_RECV, ST_FINISH
    } mter_stage_e;

    // handshake failure code for abnormal data, by stage
    function automatic logic [CODE_W-1:0] bad_data_code(mter_stage_e s);
        unique case (s)
            ST_REQ_SEND: bad_data_code = CODE_HS_50;
            ST_REQ_ACK: bad_data_code = CODE_HS_51;
            ST_RSP_WAIT: bad_data_code = CODE_HS_54;
            ST_RSP_RECV: bad_data_code = CODE_HS_55;
            default: bad_data_code = CODE_HS_58;
        endcase
    endfunction

    // timeout code: request half or response half of the handshake
    function automatic logic [CODE_W-1:0] tout_code(mter_stage_e s);
        tout_code = (s == ST_REQ_SEND || s == ST_REQ_ACK) ?
            CODE_TOUT_REQ : CODE_TOUT_RSP;
    endfunction
endpackage

// file: pkg/mter_slot_if.sv
// link between the request checker and one transfer slot
`timescale 1ns/1ns
interface mter_slot_if;
    import mter_pkg::*;
    logic start;
    logic [STN_W-1:0] start_stn;
    logic ack;
    logic active;
    logic fin;
    logic [STN_W-1:0] stn;
    logic [CODE_W-1:0] code;
    modport ctl(output start, start_stn, ack, input active, fin, stn, code);
    modport slot(input start, start_stn, ack, output active, fin, stn, code);
endinterface

// file: verilog/mter_slot.sv
// one running message transfer: stage tracking, timing, abort codes
`timescale 1ns/1ns
module mter_slot (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    mter_slot_if.slot bus,
    input wire logic tick_i,
    input wire logic [mter_pkg::MON_W-1:0] mon_time_i,
    input wire logic link_stop_i,
    input wire logic param_chg_i,
    input wire logic link_err_i,
    input wire logic [mter_pkg::STN_W-1:0] link_err_stn_i,
    input wire mter_pkg::mter_rx_e rx_kind_i,
    input wire logic [mter_pkg::STN_W-1:0] rx_stn_i
);
    import mter_pkg::*;

    mter_stage_e stage_reg, stage_next;
    logic [STN_W-1:0] stn_reg, stn_next;
    logic [MON_W-1:0] timer_reg, timer_next;
    logic fin_reg, fin_next;
    logic [CODE_W-1:0] code_reg, code_next;
    logic run, hit_link, rx_hit, tout;

    assign run = (stage_reg != ST_IDLE);
    assign hit_link = run && link_err_i && (link_err_stn_i == stn_reg);
    assign rx_hit = run && (rx_kind_i != RX_NONE) && (rx_stn_i == stn_reg);
    assign tout = run && tick_i && (timer_reg >= mon_time_i);

    always_comb begin
        stage_next = stage_reg;
        stn_next = stn_reg;
        timer_next = timer_reg;
        fin_next = fin_reg && !bus.ack;
        code_next = code_reg;
        if (!run && !fin_reg && bus.start) begin
            stage_next = ST_REQ_SEND;
            stn_next = bus.start_stn;
            timer_next = '0;
        end else if (run) begin
            if (tick_i)
                timer_next = timer_reg + 1'b1;
            fin_next = 1'b1;
            stage_next = ST_IDLE;
            if (param_chg_i || hit_link) begin
                code_next = CODE_HS_50;
            end else if (link_stop_i || tout) begin
                code_next = tout_code(stage_reg);
            end else if (rx_hit && rx_kind_i == RX_BAD_RSP) begin
                code_next = CODE_BAD_RSP;
            end else if (rx_hit && rx_kind_i == RX_BAD_DATA) begin
                code_next = bad_data_code(stage_reg);
            end else if (rx_hit && stage_reg == ST_FINISH) begin
                code_next = CODE_OK;
            end else begin
                fin_next = 1'b0;
                stage_next = stage_reg;
                if (rx_hit) begin
                    stage_next = mter_stage_e'(stage_reg + 3'h1);
                    timer_next = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage_reg <= ST_IDLE;
            stn_reg <= '0;
            timer_reg <= '0;
            fin_reg <= 1'b0;
            code_reg <= CODE_OK;
        end else begin
            stage_reg <= stage_next;
            stn_reg <= stn_next;
            timer_reg <= timer_next;
            fin_reg <= fin_next;
            code_reg <= code_next;
        end
    end

    assign bus.active = run;
    assign bus.fin = fin_reg;
    assign bus.stn = stn_reg;
    assign bus.code = code_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_link_err_abort: assert property (
        hit_link |=> fin_reg && !run && code_reg == CODE_HS_50)
        else $error("link error did not end transfer with BC50");
    chk_param_abort: assert property (
        run && param_chg_i |=> fin_reg && code_reg == CODE_HS_50)
        else $error("parameter change did not end transfer with BC50");
    chk_timeout_code: assert property (
        tout && !param_chg_i && !hit_link |=> fin_reg &&
        code_reg == tout_code($past(stage_reg)))
        else $error("handshake timeout code wrong");
    chk_stop_abort: assert property (
        run && link_stop_i && !param_chg_i && !hit_link
        |=> fin_reg && (code_reg == CODE_TOUT_REQ ||
        code_reg == CODE_TOUT_RSP))
        else $error("link stop did not time out transfer");
    chk_bad_data_code: assert property (
        rx_hit && rx_kind_i == RX_BAD_DATA && !param_chg_i && !hit_link &&
        !link_stop_i && !tout |=> code_reg == bad_data_code($past(stage_reg)))
        else $error("abnormal data code wrong for stage");
    chk_bad_rsp_code: assert property (
        rx_hit && rx_kind_i == RX_BAD_RSP && !param_chg_i && !hit_link &&
        !link_stop_i && !tout |=> fin_reg && code_reg == CODE_BAD_RSP)
        else $error("abnormal response not reported as BC5B");
endmodule

// file: verification/mter_far_model.sv
// behavioural model of the remote stations answering transfers
`timescale 1ns/1ns
module mter_far_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic [mter_pkg::STN_W-1:0] stn_i,
    input wire logic [2:0] steps_i,
    input wire mter_pkg::mter_rx_e last_i,
    output mter_pkg::mter_rx_e rx_kind_o,
    output logic [mter_pkg::STN_W-1:0] rx_stn_o
);
    import mter_pkg::*;
    logic busy;
    logic ph;
    logic [2:0] left;
    logic [STN_W-1:0] stn;
    mter_rx_e fin;
    // ------------------------------------------------------------------
    // step every other cycle, then the commanded last answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy <= 1'b0;
            ph <= 1'b0;
            left <= 3'h0;
            stn <= '0;
            fin <= RX_NONE;
            rx_kind_o <= RX_NONE;
            rx_stn_o <= '0;
        end else if (go_i) begin
            busy <= 1'b1;
            ph <= 1'b0;
            left <= steps_i;
            stn <= stn_i;
            fin <= last_i;
            rx_kind_o <= RX_NONE;
        end else if (busy && !ph) begin
            ph <= 1'b1;
            rx_stn_o <= stn;
            if (left != 3'h0) begin
                rx_kind_o <= RX_STEP;
                left <= left - 3'h1;
            end else begin
                // abnormal data only when a scenario commands it
                rx_kind_o <= fin;
                busy <= 1'b0;
            end
        end else begin
            // released: station field changes every cycle
            ph <= 1'b0;
            rx_kind_o <= RX_NONE;
            rx_stn_o <= ~rx_stn_o;
        end
    end
endmodule

// file: verification/message_transfer_error_reporter_tb.sv
// self-checking bench of the message transfer error reporter
`timescale 1ns/1ns
module message_transfer_error_reporter_tb;
    import mter_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_periph_i = 1'b0;
    logic [STN_W-1:0] req_stn_i = '0;
    logic [SIZE_W-1:0] req_size_i = '0;
    logic master_role_i = 1'b1;
    logic [MON_W-1:0] mon_i = 16'h0400;
    logic link_stop_i = 1'b0;
    logic param_chg_i = 1'b0;
    logic link_err_i = 1'b0;
    logic [STN_W-1:0] link_err_stn_i = '0;
    mter_rx_e rx_kind;
    logic [STN_W-1:0] rx_stn;
    logic go = 1'b0;
    logic [STN_W-1:0] go_stn = '0;
    logic [2:0] go_steps = 3'h0;
    mter_rx_e go_last = RX_NONE;
    logic done_o;
    logic [STN_W-1:0] done_stn_o;
    logic [CODE_W-1:0] err_code_o;
    logic periph_grant_o;
    logic [CNT_W-1:0] busy_cnt_o;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [CODE_W-1:0] bad_tab [5] = '{CODE_HS_50, CODE_HS_51, CODE_HS_54,
        CODE_HS_55, CODE_HS_58};

    always #20 clk_sys_i = ~clk_sys_i;

    mter_top #(.TICK_CYCLES(4)) DUT (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_periph_i(req_periph_i), .req_stn_i(req_stn_i),
        .req_size_i(req_size_i), .master_role_i(master_role_i),
        .monitoring_time_word_i(mon_i), .link_stop_request_bit_i(link_stop_i),
        .param_chg_i(param_chg_i), .link_err_i(link_err_i),
        .link_err_stn_i(link_err_stn_i), .rx_kind_i(rx_kind),
        .rx_stn_i(rx_stn), .done_o(done_o), .done_stn_o(done_stn_o),
        .err_code_o(err_code_o), .periph_grant_o(periph_grant_o),
        .busy_cnt_o(busy_cnt_o));

    mter_far_model far (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .go_i(go), .stn_i(go_stn),
        .steps_i(go_steps), .last_i(go_last), .rx_kind_o(rx_kind),
        .rx_stn_o(rx_stn));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic req(input logic p, input logic [STN_W-1:0] s,
        input logic [SIZE_W-1:0] z);
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_periph_i <= p;
        req_stn_i <= s;
        req_size_i <= z;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
    endtask

    task automatic run(input logic [STN_W-1:0] s, input logic [2:0] n,
        input mter_rx_e last);
        @(posedge clk_sys_i);
        go <= 1'b1;
        go_stn <= s;
        go_steps <= n;
        go_last <= last;
        @(posedge clk_sys_i);
        go <= 1'b0;
    endtask

    task automatic wait_done(input logic [CODE_W-1:0] code,
        input logic [STN_W-1:0] s);
        logic found;
        found = 1'b0;
        // look in the current cycle first: a refusal pulses right away
        for (int i = 0; i < 300 && !found; i++) begin
            #1;
            if (done_o === 1'b1)
                found = 1'b1;
            else
                @(posedge clk_sys_i);
        end
        check(found, 1'b1);
        check(err_code_o, code);
        check(done_stn_o, s);
        // hand back on a rising edge so callers drive on the edge
        @(posedge clk_sys_i);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_walk();
        req(1'b0, 7'h03, 11'h00A);
        run(7'h03, 3'h4, RX_STEP);
        wait_done(CODE_OK, 7'h03);
    endtask

    task automatic t_refuse();
        @(posedge clk_sys_i);
        master_role_i <= 1'b0;
        req(1'b0, 7'h07, 11'h00A);
        wait_done(CODE_NOT_MASTER, 7'h07);
        master_role_i <= 1'b1;
        req(1'b0, 7'h07, 11'h000);
        wait_done(CODE_SIZE, 7'h07);
        req(1'b0, 7'h07, 11'h3C1);
        wait_done(CODE_SIZE, 7'h07);
        req(1'b0, 7'h08, 11'h3C0);
        @(posedge clk_sys_i);
        link_err_i <= 1'b1;
        link_err_stn_i <= 7'h08;
        @(posedge clk_sys_i);
        link_err_i <= 1'b0;
        wait_done(CODE_HS_50, 7'h08);
    endtask

    task automatic t_overlap();
        req(1'b0, 7'h05, 11'h00A);
        req(1'b0, 7'h05, 11'h00A);
        wait_done(CODE_OVERLAP, 7'h05);
        req(1'b1, 7'h05, 11'h000);
        wait_done(CODE_OVERLAP, 7'h05);
        req(1'b1, 7'h06, 11'h000);
        #1;
        check(periph_grant_o, 1'b1);
        // deliberate change during a running transfer
        @(posedge clk_sys_i);
        param_chg_i <= 1'b1;
        @(posedge clk_sys_i);
        param_chg_i <= 1'b0;
        wait_done(CODE_HS_50, 7'h05);
    endtask

    task automatic t_many();
        for (int s = 10; s < 14; s++)
            req(1'b0, 7'(s), 11'h00A);
        @(posedge clk_sys_i);
        #1;
        check(busy_cnt_o, 3'h4);
        req(1'b0, 7'h0E, 11'h00A);
        wait_done(CODE_TOO_MANY, 7'h0E);
        // deliberate stop with transfers still running
        link_stop_i <= 1'b1;
        for (int s = 10; s < 14; s++)
            wait_done(CODE_TOUT_REQ, 7'(s));
        link_stop_i <= 1'b0;
    endtask

    task automatic t_tout();
        @(posedge clk_sys_i);
        mon_i <= 16'h0002;
        req(1'b0, 7'h14, 11'h00A);
        wait_done(CODE_TOUT_REQ, 7'h14);
        req(1'b0, 7'h15, 11'h00A);
        run(7'h15, 3'h2, RX_NONE);
        wait_done(CODE_TOUT_RSP, 7'h15);
        mon_i <= 16'h0400;
    endtask

    task automatic t_bad();
        for (int k = 0; k < 5; k++) begin
            req(1'b0, 7'(30 + k), 11'h00A);
            run(7'(30 + k), 3'(k), RX_BAD_DATA);
            wait_done(bad_tab[k], 7'(30 + k));
        end
        req(1'b0, 7'h28, 11'h00A);
        run(7'h28, 3'h2, RX_BAD_RSP);
        wait_done(CODE_BAD_RSP, 7'h28);
    endtask
    // ------------------------------------------------------------------
    // hang guard and main sequence
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        check(err_code_o, CODE_OK);
        t_walk();
        t_refuse();
        t_overlap();
        t_many();
        t_tout();
        t_bad();
        repeat (4) @(posedge clk_sys_i);
        #1;
        check(busy_cnt_o, 3'h0);
        complete_run();
    end
endmodule
